// [rtl/pdzq_pkg.sv]
/*
  Shared constants for the memory-side power-down and impedance calibration block:
  command encodings, calibration windows, default timing counts in memory clocks.
  Assumes the block sees the memory clock and command bus as asynchronous pins.
*/
package pdzq_pkg;
  // command codes as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_ZQ      = 4'h6;
  localparam logic [3:0] CMD_WRITE   = 4'h4;
  localparam logic [3:0] CMD_DESEL_MASK = 4'h8;
  // calibration windows in memory clocks
  localparam int ZQINIT_NCK  = 512;
  localparam int ZQOPER_NCK  = 256;
  localparam int ZQCS_NCK    = 64;
  // default timing counts in memory clocks
  localparam int CKE_MIN_NCK = 3;
  localparam int XP_NCK      = 3;
  localparam int XPDLL_NCK   = 10;
  localparam int RFC_NCK     = 110;
  localparam int XS_NCK      = 120;
  // write recovery, fixed here in place of the mode register zero field
  localparam int WR_NCK      = 8;
  localparam int CNT_W       = 10;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  typedef enum logic [1:0] {ZQ_IDLE, ZQ_ENGINE, ZQ_TRANSFER} zq_state_type;
endpackage

// [rtl/pdzq_ctrl.sv]
/*
  Memory-side tracker for power-down entry and exit, refresh spacing and impedance
  calibration. Samples the memory clock, clock enable, command and address pins
  in the fast system clock; reports power-down state, calibration progress,
  updated impedance codes and controller timing violations.
  Assumes the memory clock runs well below the system clock (125 ns in the bench).
*/
`timescale 1ns/1ps
module pdzq_ctrl
  import pdzq_pkg::*;
#(
  parameter int CODE_W = 6
) (
  // system
  input  wire logic              CLK,
  input  wire logic              RST_B,
  // memory pins
  input  wire logic              MEM_CK,
  input  wire logic              MEM_CKE,
  input  wire logic [3:0]        MEM_CMD,
  input  wire logic              MEM_A10,
  input  wire logic              MEM_ODT,
  // calibration comparator and strap
  input  wire logic              ZQ_CMP_HIGH,
  input  wire logic              SELF_REFRESH_EXIT,
  // status
  output logic                   POWER_DOWN,
  output logic                   CAL_BUSY,
  output logic                   CAL_CURRENT_EN,
  output logic                   DQ_DRIVE_OFF,
  output logic [CODE_W-1:0]      IMPEDANCE_CODE,
  output logic                   TIMING_ERROR
);
  if (CODE_W < 2 || CODE_W > 8) begin : g_code_w_check
    $error("CODE_W out of range");
  end

  // two-flop synchronisers for all pins
  logic [8:0] s1_reg, s2_reg;
  logic       ck_old_reg;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      s1_reg     <= 9'h000;
      s2_reg     <= 9'h000;
      ck_old_reg <= 1'b0;
    end else begin
      s1_reg     <= {SELF_REFRESH_EXIT, ZQ_CMP_HIGH, MEM_ODT, MEM_A10, MEM_CMD, MEM_CK};
      s2_reg     <= s1_reg;
      ck_old_reg <= s2_reg[0];
    end
  end
  logic       ck_rise;
  logic       cke_s, a10_s, odt_s, cmp_s, srx_s;
  logic [3:0] cmd_s;
  assign ck_rise = s2_reg[0] & ~ck_old_reg;
  assign cmd_s   = s2_reg[4:1];
  assign a10_s   = s2_reg[5];
  assign odt_s   = s2_reg[6];
  assign cmp_s   = s2_reg[7];
  assign srx_s   = s2_reg[8];
  // clock enable sampled separately so its level is stable at each edge
  logic cke1_reg, cke2_reg;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      cke1_reg <= 1'b0;
      cke2_reg <= 1'b0;
    end else begin
      cke1_reg <= MEM_CKE;
      cke2_reg <= cke1_reg;
    end
  end
  assign cke_s = cke2_reg;

  logic idle_cmd;
  assign idle_cmd = ((cmd_s & CMD_DESEL_MASK) != 4'h0) | (cmd_s == CMD_NOP);

  // power-down and timing tracking, all counts in memory clocks
  logic             pd_reg, pd_next, cke_prev_reg, cke_prev_next;
  logic [CNT_W-1:0] res_reg, res_next, xp_reg, xp_next, xpdll_reg, xpdll_next;
  logic [CNT_W-1:0] rfc_reg, rfc_next, xs_reg, xs_next;
  logic [CNT_W-1:0] wr_reg, wr_next;
  logic             low_in_rfc_reg, low_in_rfc_next, err_reg, err_next;
  logic             cal_active;
  logic             zq_cmd, ref_cmd;
  assign zq_cmd  = ck_rise & cke_s & (cmd_s == CMD_ZQ);
  assign ref_cmd = ck_rise & cke_s & (cmd_s == CMD_REFRESH);

  function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
    return (v == CNT_ZERO) ? CNT_ZERO : v - 10'h001;
  endfunction

  always_comb begin
    pd_next         = pd_reg;
    cke_prev_next   = cke_prev_reg;
    res_next        = res_reg;
    xp_next         = xp_reg;
    xpdll_next      = xpdll_reg;
    rfc_next        = rfc_reg;
    xs_next         = xs_reg;
    wr_next         = wr_reg;
    low_in_rfc_next = low_in_rfc_reg;
    err_next        = 1'b0;
    if (ck_rise) begin
      cke_prev_next = cke_s;
      res_next      = dec(res_reg);
      xp_next       = dec(xp_reg);
      xpdll_next    = dec(xpdll_reg);
      rfc_next      = dec(rfc_reg);
      xs_next       = dec(xs_reg);
      wr_next       = dec(wr_reg);
      // entry on low edge with idle
      if (!pd_reg && cke_prev_reg && !cke_s && idle_cmd) begin
        pd_next = 1'b1;
        // residency equals minimum enable pulse
        // loads are one short: the count reads zero on the edge ending the span
        res_next = CNT_W'(CKE_MIN_NCK - 1);
        // no re-entry inside DLL exit latency
        if (xpdll_reg != CNT_ZERO) err_next = 1'b1;
        if (wr_reg != CNT_ZERO) err_next = 1'b1;
        if (rfc_reg != CNT_ZERO) begin
          if (low_in_rfc_reg) err_next = 1'b1;
          low_in_rfc_next = 1'b1;
        end
        // enable must stay high while calibrating
        if (cal_active) err_next = 1'b1;
      end
      // exit on high edge, flagged unless idle and residency met
      if (pd_reg && cke_s) begin
        pd_next    = 1'b0;
        xp_next    = CNT_W'(XP_NCK - 1);
        xpdll_next = CNT_W'(XPDLL_NCK - 1);
        if (res_reg != CNT_ZERO) err_next = 1'b1;
        if (!idle_cmd) err_next = 1'b1;
      end
      if (!pd_reg && cke_s && !idle_cmd) begin
        if (xp_reg != CNT_ZERO) err_next = 1'b1;
        // only idle until refresh cycle ends
        if (low_in_rfc_reg && rfc_reg != CNT_ZERO) err_next = 1'b1;
        if (cal_active) err_next = 1'b1;
      end
      if (ref_cmd) begin
        rfc_next        = CNT_W'(RFC_NCK - 1);
        low_in_rfc_next = 1'b0;
      end
      if (cke_s && a10_s && cmd_s == CMD_WRITE) wr_next = CNT_W'(WR_NCK - 1);
      // calibration not before self-refresh exit delay
      if (zq_cmd && xs_reg != CNT_ZERO) err_next = 1'b1;
      if (cal_active && odt_s) err_next = 1'b1;
    end
    // self-refresh exit starts only its own delay, no lock wait
    if (srx_s && !pd_reg) xs_next = CNT_W'(XS_NCK - 1);
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pd_reg         <= 1'b0;
      cke_prev_reg   <= 1'b0;
      res_reg        <= CNT_ZERO;
      xp_reg         <= CNT_ZERO;
      xpdll_reg      <= CNT_ZERO;
      rfc_reg        <= CNT_ZERO;
      xs_reg         <= CNT_ZERO;
      wr_reg         <= CNT_ZERO;
      low_in_rfc_reg <= 1'b0;
      err_reg        <= 1'b0;
    end else begin
      pd_reg         <= pd_next;
      cke_prev_reg   <= cke_prev_next;
      res_reg        <= res_next;
      xp_reg         <= xp_next;
      xpdll_reg      <= xpdll_next;
      rfc_reg        <= rfc_next;
      xs_reg         <= xs_next;
      wr_reg         <= wr_next;
      low_in_rfc_reg <= low_in_rfc_next;
      err_reg        <= err_next;
    end
  end

  // calibration engine: successive steps on the comparator, then transfer
  zq_state_type     zq_reg, zq_next;
  logic [CNT_W-1:0] win_reg, win_next;
  logic             first_long_reg, first_long_next;
  logic [CODE_W-1:0] work_reg, work_next, code_reg, code_next;
  assign cal_active = (zq_reg != ZQ_IDLE);

  always_comb begin
    zq_next         = zq_reg;
    win_next        = win_reg;
    first_long_next = first_long_reg;
    work_next       = work_reg;
    code_next       = code_reg;
    case (zq_reg)
      ZQ_IDLE: begin
        // only an explicit command starts calibration
        // a command inside the exit delay is refused
        if (zq_cmd && xs_reg == CNT_ZERO) begin
          zq_next = ZQ_ENGINE;
          if (a10_s) begin
            // first long gets the init window
            win_next        = first_long_reg ? CNT_W'(ZQINIT_NCK) : CNT_W'(ZQOPER_NCK);
            first_long_next = 1'b0;
          end else begin
            win_next = CNT_W'(ZQCS_NCK);
          end
          work_next = code_reg;
        end
      end
      ZQ_ENGINE: begin
        // engine steps one code per memory clock
        if (ck_rise) begin
          win_next = dec(win_reg);
          if (cmp_s && work_reg != {CODE_W{1'b1}}) work_next = work_reg + 1'b1;
          if (!cmp_s && work_reg != {CODE_W{1'b0}}) work_next = work_reg - 1'b1;
          if (win_reg == 10'h002) zq_next = ZQ_TRANSFER;
        end
      end
      ZQ_TRANSFER: begin
        // transfer result into drivers and termination
        if (ck_rise) begin
          code_next = work_reg;
          win_next  = CNT_ZERO;
          zq_next   = ZQ_IDLE;
        end
      end
      default: zq_next = ZQ_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      zq_reg         <= ZQ_IDLE;
      win_reg        <= CNT_ZERO;
      first_long_reg <= 1'b1;
      work_reg       <= {1'b1, {(CODE_W-1){1'b0}}};
      code_reg       <= {1'b1, {(CODE_W-1){1'b0}}};
    end else begin
      zq_reg         <= zq_next;
      win_reg        <= win_next;
      first_long_reg <= first_long_next;
      work_reg       <= work_next;
      code_reg       <= code_next;
    end
  end

  assign POWER_DOWN     = pd_reg;
  assign CAL_BUSY       = cal_active;
  // reference current only while the engine runs
  assign CAL_CURRENT_EN = (zq_reg == ZQ_ENGINE);
  assign DQ_DRIVE_OFF   = cal_active;
  assign IMPEDANCE_CODE = code_reg;
  assign TIMING_ERROR   = err_reg;
endmodule

// [tb/pdzq_ctrl_sva.sv]
/* checker of the tracker status outputs.
   assumes binding to pdzq_ctrl, one clock domain. */
`timescale 1ns/1ps
module pdzq_ctrl_sva #(
  parameter int CODE_W = 6
) (
  // system
  input wire logic              CLK,
  input wire logic              RST_B,
  // status
  input wire logic              POWER_DOWN,
  input wire logic              CAL_BUSY,
  input wire logic              CAL_CURRENT_EN,
  input wire logic              DQ_DRIVE_OFF,
  input wire logic [CODE_W-1:0] IMPEDANCE_CODE,
  input wire logic              TIMING_ERROR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  chk_dq_released: assert property (DQ_DRIVE_OFF == CAL_BUSY)
    else $error("data outputs not released");
  chk_current_gated: assert property (CAL_CURRENT_EN |-> CAL_BUSY)
    else $error("current on outside window");
  chk_transfer_last: assert property ($fell(CAL_BUSY) |-> !$past(CAL_CURRENT_EN, 8))
    else $error("no transfer phase");
  chk_code_hold: assert property ((CAL_BUSY || !$past(CAL_BUSY)) |-> $stable(IMPEDANCE_CODE))
    else $error("code moved outside window end");
  chk_engine_first: assert property ($rose(CAL_BUSY) |-> CAL_CURRENT_EN ##1 CAL_BUSY [*8])
    else $error("engine not started");
  chk_zq_accepted: assert property ($rose(CAL_BUSY) |-> !TIMING_ERROR [*8])
    else $error("valid calibration flagged");
  chk_pd_on_edges: assert property ($changed(POWER_DOWN) |=> $stable(POWER_DOWN) [*8])
    else $error("power-down toggled between edges");
  chk_error_pulse: assert property (TIMING_ERROR |=> !TIMING_ERROR)
    else $error("error flag longer than a pulse");
  cov_pd: cover property ($rose(POWER_DOWN));
  cov_cal: cover property ($fell(CAL_BUSY));
  cov_err: cover property (TIMING_ERROR);
endmodule
bind pdzq_ctrl pdzq_ctrl_sva #(.CODE_W(CODE_W)) chk_u (.CLK(CLK), .RST_B(RST_B),
  .POWER_DOWN(POWER_DOWN), .CAL_BUSY(CAL_BUSY), .CAL_CURRENT_EN(CAL_CURRENT_EN),
  .DQ_DRIVE_OFF(DQ_DRIVE_OFF), .IMPEDANCE_CODE(IMPEDANCE_CODE),
  .TIMING_ERROR(TIMING_ERROR));

// [tb/mem_ctrl_model.sv]
/* controller model on the memory pins.
   assumes pins launch on the bench CLK, mid memory period. */
`timescale 1ns/1ps
module mem_ctrl_model
  import pdzq_pkg::*;
(
  // system
  input  wire logic       CLK,
  // memory pins
  output logic            MEM_CK,
  output logic            MEM_CKE,
  output logic [3:0]      MEM_CMD,
  output logic            MEM_A10,
  output logic            MEM_ODT
);
  // free running: power-down needs a stable clock
  initial begin
    MEM_CK = 1'b0;
    forever #62.5 MEM_CK = ~MEM_CK;
  end
  initial begin
    MEM_CKE = 1'b1;
    MEM_CMD = CMD_NOP;
    MEM_A10 = 1'b0;
    MEM_ODT = 1'b0;
  end
  // one device, brief spells, counted timings
  // no bank open, idle after each command
  task automatic send(input logic cke, input logic [3:0] cmd, input logic a10, input int n);
    @(negedge MEM_CK);
    @(posedge CLK);
    MEM_CKE <= cke;
    MEM_CMD <= cmd;
    MEM_A10 <= a10;
    @(negedge MEM_CK);
    @(posedge CLK);
    MEM_CMD <= CMD_NOP;
    MEM_A10 <= ~a10;
    repeat (n) @(posedge MEM_CK);
  endtask
  // termination raised on purpose to provoke the flag
  task automatic odt(input logic v);
    @(posedge CLK);
    MEM_ODT <= v;
  endtask
endmodule

// [tb/tb_pdzq_ctrl.sv]
/* bench of the power-down and calibration tracker.
   assumes the controller model drives all memory pins. */
`timescale 1ns/1ps
module tb_pdzq_ctrl
  import pdzq_pkg::*;
;
  logic       CLK, RST_B, MEM_CK, MEM_CKE, MEM_A10, MEM_ODT, ZQ_CMP_HIGH, SELF_REFRESH_EXIT;
  logic       POWER_DOWN, CAL_BUSY, CAL_CURRENT_EN, DQ_DRIVE_OFF, TIMING_ERROR;
  logic [3:0] MEM_CMD;
  logic [5:0] IMPEDANCE_CODE;
  int         miscompares, checked, errs, mark, run, len;
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  pdzq_ctrl dut_u (.CLK(CLK), .RST_B(RST_B), .MEM_CK(MEM_CK), .MEM_CKE(MEM_CKE),
    .MEM_CMD(MEM_CMD), .MEM_A10(MEM_A10), .MEM_ODT(MEM_ODT), .ZQ_CMP_HIGH(ZQ_CMP_HIGH),
    .SELF_REFRESH_EXIT(SELF_REFRESH_EXIT), .POWER_DOWN(POWER_DOWN), .CAL_BUSY(CAL_BUSY),
    .CAL_CURRENT_EN(CAL_CURRENT_EN), .DQ_DRIVE_OFF(DQ_DRIVE_OFF),
    .IMPEDANCE_CODE(IMPEDANCE_CODE), .TIMING_ERROR(TIMING_ERROR));
  mem_ctrl_model ctrl_u (.CLK(CLK), .MEM_CK(MEM_CK), .MEM_CKE(MEM_CKE), .MEM_CMD(MEM_CMD),
    .MEM_A10(MEM_A10), .MEM_ODT(MEM_ODT));
  always @(posedge CLK) begin
    if (TIMING_ERROR === 1'b1) errs <= errs + 1;
    if (CAL_BUSY === 1'b1) run <= run + 1;
    else if (run != 0) begin
      len <= run;
      run <= 0;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic fault(input logic exp);
    check(errs != mark, exp);
    mark = errs;
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic pd_ok;
    ctrl_u.send(1'b0, CMD_NOP, 1'b0, 2);
    check(POWER_DOWN, 1'b1);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 9);
    check(POWER_DOWN, 1'b0);
    ctrl_u.send(1'b0, CMD_NOP, 1'b0, 2);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 12);
    fault(1'b0);
  endtask
  task automatic pd_write;
    ctrl_u.send(1'b1, CMD_WRITE, 1'b1, 2);
    ctrl_u.send(1'b0, CMD_NOP, 1'b0, 2);
    fault(1'b1);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 12);
    ctrl_u.send(1'b1, CMD_WRITE, 1'b1, 7);
    ctrl_u.send(1'b0, CMD_NOP, 1'b0, 2);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 12);
    fault(1'b0);
  endtask
  task automatic pd_bad;
    ctrl_u.send(1'b0, CMD_NOP, 1'b0, 1);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 12);
    fault(1'b1);
    ctrl_u.send(1'b0, CMD_NOP, 1'b0, 2);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 8);
    ctrl_u.send(1'b0, CMD_NOP, 1'b0, 2);
    fault(1'b1);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 12);
  endtask
  task automatic pd_refresh;
    ctrl_u.send(1'b0, CMD_NOP, 1'b0, 2);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 0);
    ctrl_u.send(1'b1, CMD_REFRESH, 1'b0, 0);
    fault(1'b1);
    ctrl_u.send(1'b1, CMD_REFRESH, 1'b0, 5);
    fault(1'b0);
    ctrl_u.send(1'b0, CMD_NOP, 1'b0, 2);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 9);
    ctrl_u.send(1'b0, CMD_NOP, 1'b0, 2);
    fault(1'b1);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 9);
    ctrl_u.send(1'b1, CMD_REFRESH, 1'b0, 0);
    fault(1'b1);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 120);
  endtask
  task automatic zq(input logic a10, input logic cmp, input int n, input logic [5:0] code);
    @(posedge CLK);
    ZQ_CMP_HIGH <= cmp;
    ctrl_u.send(1'b1, CMD_ZQ, a10, 2);
    check(CAL_BUSY & DQ_DRIVE_OFF, 1'b1);
    check(CAL_CURRENT_EN, 1'b1);
    ctrl_u.send(1'b1, CMD_REFRESH, 1'b0, 0);
    fault(1'b1);
    ctrl_u.odt(1'b1);
    repeat (60) @(posedge CLK);
    ctrl_u.odt(1'b0);
    repeat (40) @(posedge CLK);
    fault(1'b1);
    for (int i = 0; i < 20000 && CAL_BUSY === 1'b1; i++) @(posedge CLK);
    @(posedge CLK);
    #1;
    check((len * 4 + 62) / 125, n);
    check(IMPEDANCE_CODE, code);
  endtask
  task automatic zq_early;
    @(posedge CLK);
    SELF_REFRESH_EXIT <= 1'b1;
    repeat (40) @(posedge CLK);
    SELF_REFRESH_EXIT <= 1'b0;
    ctrl_u.send(1'b1, CMD_ZQ, 1'b0, 2);
    fault(1'b1);
    check(CAL_BUSY, 1'b0);
    ctrl_u.send(1'b1, CMD_NOP, 1'b0, 120);
  endtask
  initial begin
    RST_B = 1'b0;
    ZQ_CMP_HIGH = 1'b1;
    SELF_REFRESH_EXIT = 1'b0;
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    #1;
    check(IMPEDANCE_CODE, 6'h20);
    pd_ok;
    pd_write;
    pd_bad;
    pd_refresh;
    zq(1'b1, 1'b1, ZQINIT_NCK, 6'h3f);
    zq_early;
    zq(1'b1, 1'b0, ZQOPER_NCK, 6'h00);
    zq(1'b0, 1'b1, ZQCS_NCK, 6'h3f);
    conclude;
  end
  initial begin
    #300000;
    miscompares++;
    conclude;
  end
endmodule
